// File: dac_pkg.sv
// Shared constants and helpers for the serial DAC load logic and its host.
package dac_pkg;

	// =====================================================================
	// Word format
	// =====================================================================
	localparam int WORD_W = 16;
	localparam int SEG_MSBS = 4;
	localparam int SEG_N = 15;
	localparam int LOW_W = WORD_W - SEG_MSBS;
	localparam logic [WORD_W-1:0] ZERO_CODE = 16'h0000;
	localparam logic [WORD_W-1:0] MID_CODE = 16'h8000;
	localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
	localparam logic [SEG_N-1:0] SEG_RST = 15'h0000;

	// =====================================================================
	// Host timing at 250 MHz
	// =====================================================================
	localparam int CORE_PERIOD_PS = 4000;
	localparam int CLEAR_MIN_NS = 10;
	localparam int CLEAR_CYC = (CLEAR_MIN_NS * 1000 + CORE_PERIOD_PS - 1)
		/ CORE_PERIOD_PS;
	// Half period of the serial clock in core cycles: 16 ns, 31.25 MHz.
	localparam int HALF_CYC = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
	localparam logic [3:0] BIT_RST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'hF;

	typedef enum logic [2:0]
	{
		H_IDLE = 3'b000,
		H_LOW = 3'b001,
		H_HIGH = 3'b010,
		H_HOLD = 3'b011,
		H_GAP = 3'b100,
		H_CLEAR = 3'b101
	} host_state_t;

	// Reset and clear value of the latch for a given variant.
	function automatic logic [WORD_W-1:0] clear_code(input logic bipolar);
		clear_code = bipolar ? MID_CODE : ZERO_CODE;
	endfunction : clear_code

	// Zeroes the trailing don't-care bits of narrower variants.
	function automatic logic [WORD_W-1:0] res_mask(input int res);
		res_mask = 16'hFFFF << (WORD_W - res);
	endfunction : res_mask

	// Thermometer decode: segment i is on when the top nibble exceeds i.
	function automatic logic [SEG_N-1:0] therm(input logic [3:0] top);
		logic [SEG_N-1:0] t;
		t = SEG_RST;
		for (int i = 0; i < SEG_N; i++)
			t[i] = (top > i[3:0]);
		therm = t;
	endfunction : therm

endpackage : dac_pkg

// File: dac_link_if.sv
// Serial link wires between the host controller and the DAC load logic.
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic async_clear_n;

	modport device
	(
		input sclk,
		input cs_n,
		input sdi,
		input async_clear_n
	);

	modport host
	(
		output sclk,
		output cs_n,
		output sdi,
		output async_clear_n
	);
endinterface : dac_link_if
`default_nettype wire

// File: dac_serial_load_logic.sv
// Device end: serial shift register, DAC latch and segment decode.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_logic
	import dac_pkg::*;
#(
	parameter int RESOLUTION = 16,
	parameter logic BIPOLAR = 1'b0
)
(
	dac_link_if.device link,
	input wire logic arst_n,
	output logic [WORD_W-1:0] dac_code,
	output logic [SEG_N-1:0] segment_on,
	output logic [LOW_W-1:0] binary_bits
);

	// =====================================================================
	// Shift register on the serial clock
	// =====================================================================
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] shift_nxt;

	// A plain 16-bit window: surplus clocks push older bits out the top.
	always_comb
	begin
		if (link.cs_n)
			shift_nxt = shift_r;
		else
			shift_nxt = {shift_r[WORD_W-2:0], link.sdi};
	end

	always_ff @(posedge link.sclk or negedge arst_n)
	begin
		if (!arst_n)
			shift_r <= SHIFT_RST;
		else
			shift_r <= shift_nxt;
	end

	// =====================================================================
	// DAC latch on the rising edge of chip select
	// =====================================================================
	localparam logic [WORD_W-1:0] RST_CODE = clear_code(BIPOLAR);
	localparam logic [SEG_N-1:0] RST_SEG = therm(RST_CODE[15:12]);

	logic [WORD_W-1:0] latch_r;
	logic [WORD_W-1:0] latch_nxt;
	logic [SEG_N-1:0] seg_r;
	logic [SEG_N-1:0] seg_nxt;

	always_comb
	begin
		latch_nxt = shift_r & res_mask(RESOLUTION);
		seg_nxt = therm(latch_nxt[15:12]);
	end

	// Clear is asynchronous and dominates, so a chip select edge while it
	// is held low cannot load anything.
	always_ff @(posedge link.cs_n or negedge arst_n
		or negedge link.async_clear_n)
	begin
		if (!arst_n)
		begin
			latch_r <= RST_CODE;
			seg_r <= RST_SEG;
		end
		else if (!link.async_clear_n)
		begin
			latch_r <= RST_CODE;
			seg_r <= RST_SEG;
		end
		else
		begin
			latch_r <= latch_nxt;
			seg_r <= seg_nxt;
		end
	end

	// The code is unsigned straight binary; the ladder weights it by k/2^N.
	assign dac_code = latch_r;
	assign segment_on = seg_r;
	assign binary_bits = latch_r[LOW_W-1:0];

endmodule : dac_serial_load_logic
`default_nettype wire

// File: dac_host_ctrl.sv
// Host end: word FIFO and serial frame generator driving the DAC link.
`timescale 1ns/1ps
`default_nettype none
module word_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] wr_nxt;
	logic [AW-1:0] rd_r;
	logic [AW-1:0] rd_nxt;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic push;
	logic pop;

	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
		rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = (AW+1)'(cnt_r + 1'b1);
		else if (pop && !push)
			cnt_nxt = (AW+1)'(cnt_r - 1'b1);
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage has no reset; only written words are ever read.
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_r] <= in_data;
	end
endmodule : word_fifo

module dac_host_ctrl
	import dac_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WORD_W-1:0] wr_data,
	input wire logic clear_req,
	output logic busy,
	dac_link_if.host link
);

	// =====================================================================
	// Word FIFO
	// =====================================================================
	logic f_valid;
	logic f_ready;
	logic [WORD_W-1:0] f_data;

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.core_clk(core_clk),
		.arst_n(arst_n),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// =====================================================================
	// Frame generator
	// =====================================================================
	host_state_t st_r;
	host_state_t st_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [WORD_W-1:0] word_r;
	logic [WORD_W-1:0] word_nxt;
	logic sclk_r;
	logic sclk_nxt;
	logic cs_n_r;
	logic cs_n_nxt;
	logic sdi_r;
	logic sdi_nxt;
	logic clr_n_r;
	logic clr_n_nxt;
	logic clr_pend_r;
	logic clr_pend_nxt;
	logic half_done;
	logic clr_done;

	assign half_done = (cnt_r == CNT_W'(HALF_CYC - 1));
	assign clr_done = (cnt_r == CNT_W'(CLEAR_CYC - 1));
	assign f_ready = (st_r == H_IDLE) && !clr_pend_r && f_valid;

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = CNT_W'(cnt_r + 1'b1);
		bit_nxt = bit_r;
		word_nxt = word_r;
		sclk_nxt = sclk_r;
		cs_n_nxt = cs_n_r;
		sdi_nxt = sdi_r;
		clr_n_nxt = clr_n_r;
		clr_pend_nxt = clr_pend_r || clear_req;
		case (st_r)
			H_IDLE:
			begin
				cnt_nxt = CNT_RST;
				if (clr_pend_r)
				begin
					// A request arriving now is kept pending: a further pulse serves it.
					clr_pend_nxt = clear_req;
					clr_n_nxt = 1'b0;
					st_nxt = H_CLEAR;
				end
				else if (f_valid)
				begin
					word_nxt = f_data;
					sdi_nxt = f_data[WORD_W-1];
					cs_n_nxt = 1'b0;
					bit_nxt = BIT_RST;
					st_nxt = H_LOW;
				end
			end
			H_LOW:
			begin
				if (half_done)
				begin
					sclk_nxt = 1'b1;
					cnt_nxt = CNT_RST;
					st_nxt = H_HIGH;
				end
			end
			H_HIGH:
			begin
				if (half_done)
				begin
					sclk_nxt = 1'b0;
					cnt_nxt = CNT_RST;
					if (bit_r == BIT_LAST)
						st_nxt = H_HOLD;
					else
					begin
						word_nxt = {word_r[WORD_W-2:0], 1'b0};
						sdi_nxt = word_r[WORD_W-2];
						bit_nxt = 4'(bit_r + 1'b1);
						st_nxt = H_LOW;
					end
				end
			end
			H_HOLD:
			begin
				if (half_done)
				begin
					cs_n_nxt = 1'b1;
					cnt_nxt = CNT_RST;
					st_nxt = H_GAP;
				end
			end
			H_GAP:
			begin
				if (half_done)
					st_nxt = H_IDLE;
			end
			H_CLEAR:
			begin
				if (clr_done)
				begin
					clr_n_nxt = 1'b1;
					cnt_nxt = CNT_RST;
					st_nxt = H_GAP;
				end
			end
			default:
			begin
				st_nxt = H_IDLE;
				cnt_nxt = CNT_RST;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r <= H_IDLE;
			cnt_r <= CNT_RST;
			bit_r <= BIT_RST;
			word_r <= SHIFT_RST;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			sdi_r <= 1'b0;
			clr_n_r <= 1'b1;
			clr_pend_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			word_r <= word_nxt;
			sclk_r <= sclk_nxt;
			cs_n_r <= cs_n_nxt;
			sdi_r <= sdi_nxt;
			clr_n_r <= clr_n_nxt;
			clr_pend_r <= clr_pend_nxt;
		end
	end

	assign busy = (st_r != H_IDLE) || clr_pend_r || f_valid;
	assign link.sclk = sclk_r;
	assign link.cs_n = cs_n_r;
	assign link.sdi = sdi_r;
	assign link.async_clear_n = clr_n_r;

endmodule : dac_host_ctrl
`default_nettype wire

// File: dac_link_chk.sv
// Checker for the serial link and the 16-bit unipolar load logic.
`timescale 1ns/1ps
`default_nettype none
module dac_link_chk
	import dac_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic async_clear_n,
	input wire logic [WORD_W-1:0] dac_code,
	input wire logic [SEG_N-1:0] segment_on,
	input wire logic [LOW_W-1:0] binary_bits
);
	// =====================================================================
	// Reference shift register
	// =====================================================================
	logic sclk_r;
	logic rise;
	logic [4:0] edges_r, edges_nxt;
	logic [15:0] sh_r, sh_nxt;
	assign rise = sclk && !sclk_r;
	always_comb
	begin
		edges_nxt = cs_n ? 5'h00 : edges_r + {4'h0, rise};
		sh_nxt = (rise && !cs_n) ? {sh_r[14:0], sdi} : sh_r;
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_r <= 1'b0;
			edges_r <= 5'h00;
			sh_r <= 16'h0000;
		end
		else
		begin
			sclk_r <= sclk;
			edges_r <= edges_nxt;
			sh_r <= sh_nxt;
		end
	end
	// =====================================================================
	// Properties
	// =====================================================================
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	property p_load;
		$rose(cs_n) && async_clear_n |-> dac_code == sh_r;
	endproperty
	a_load: assert property (p_load) else $error("latch differs");
	property p_edges;
		$rose(cs_n) |-> edges_r == 5'h10;
	endproperty
	a_edges: assert property (p_edges) else $error("edge count");
	property p_hold;
		cs_n && $past(cs_n) && async_clear_n |-> $stable(dac_code);
	endproperty
	a_hold: assert property (p_hold) else $error("latch moved");
	property p_clr;
		!async_clear_n |-> dac_code == ZERO_CODE;
	endproperty
	a_clr: assert property (p_clr) else $error("not cleared");
	property p_clr_w;
		$fell(async_clear_n) |-> !async_clear_n [*3];
	endproperty
	a_clr_w: assert property (p_clr_w) else $error("clear short");
	property p_no_clr;
		!cs_n |-> async_clear_n;
	endproperty
	a_no_clr: assert property (p_no_clr) else $error("clear in frame");
	property p_idle;
		cs_n |-> !sclk;
	endproperty
	a_idle: assert property (p_idle) else $error("clock idle");
	property p_seg;
		$stable(dac_code) ##1 $stable(dac_code) |->
			segment_on == 15'((16'h0001 << dac_code[15:12]) - 16'h0001);
	endproperty
	a_seg: assert property (p_seg) else $error("segments");
	property p_bin;
		binary_bits == dac_code[11:0];
	endproperty
	a_bin: assert property (p_bin) else $error("binary bits");
	c_load: cover property ($rose(cs_n));
	c_clear: cover property ($fell(async_clear_n));
	c_full: cover property ($rose(cs_n) ##1 dac_code == 16'hFFFF);
endmodule : dac_link_chk
`default_nettype wire

// File: dac_serial_load_logic_tb_top.sv
// Self-checking bench: host controller driving three DAC variants.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_logic_tb_top import dac_pkg::*;;
	typedef struct packed {logic [15:0] w, eb, ec;} row_t;
	row_t rows [5] = '{'{16'hFFFF, 16'hFFF0, 16'hFFFC},
		'{16'h8001, 16'h8000, 16'h8000}, '{16'h0001, 16'h0000, 16'h0000},
		'{16'h7ABE, 16'h7AB0, 16'h7ABC}, '{16'h1234, 16'h1230, 16'h1234}};
	logic core_clk, arst_n, wr_valid, wr_ready, clear_req, busy;
	logic [15:0] wr_data, code_a, code_b, code_c;
	logic [14:0] seg_a;
	logic [11:0] bin_a;
	int err_total, compares, refused;
	logic lclk, sclk_en;
	logic [15:0] code_d;
	dac_link_if link();
	// A second link driven by the bench reaches the cases the host never makes.
	dac_link_if link_d();
	// The gate changes only while lclk is low, so no runt pulse reaches sclk.
	assign link_d.sclk = lclk & sclk_en;
	dac_host_ctrl dac_host_ctrl_inst (.core_clk(core_clk),
		.arst_n(arst_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .clear_req(clear_req), .busy(busy), .link(link));
	dac_serial_load_logic dac_serial_load_logic_inst (.link(link),
		.arst_n(arst_n), .dac_code(code_a), .segment_on(seg_a),
		.binary_bits(bin_a));
	dac_serial_load_logic #(.RESOLUTION(12), .BIPOLAR(1'b1))
		dac_serial_load_logic_inst_b (.link(link), .arst_n(arst_n),
		.dac_code(code_b), .segment_on(), .binary_bits());
	dac_serial_load_logic #(.RESOLUTION(14))
		dac_serial_load_logic_inst_c (.link(link), .arst_n(arst_n),
		.dac_code(code_c), .segment_on(), .binary_bits());
	dac_serial_load_logic dac_serial_load_logic_inst_d (.link(link_d),
		.arst_n(arst_n), .dac_code(code_d), .segment_on(),
		.binary_bits());
	dac_link_chk dac_link_chk_inst (.core_clk(core_clk), .arst_n(arst_n),
		.sclk(link.sclk), .cs_n(link.cs_n), .sdi(link.sdi),
		.async_clear_n(link.async_clear_n), .dac_code(code_a),
		.segment_on(seg_a), .binary_bits(bin_a));
	// =====================================================================
	// Tasks
	// =====================================================================
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// Leaves the strobe up so that pushes can follow back to back.
	task automatic push(input logic [15:0] w);
		wr_valid <= 1'b1;
		wr_data <= w;
		@(negedge core_clk);
		while (wr_ready !== 1'b1)
		begin
			refused++;
			@(negedge core_clk);
		end
		@(posedge core_clk);
	endtask : push
	task automatic settle;
		wr_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 3000 && busy !== 1'b0; i++)
			@(negedge core_clk);
		if (busy !== 1'b0)
			err_total++;
	endtask : settle
	// Sends the low n bits of w, oldest first, with sel high pulling chip select low.
	// Data moves on the falling edge so that each rise sees it settled.
	task automatic bang(input logic [31:0] w, input int n,
		input logic sel);
		@(negedge lclk);
		link_d.cs_n <= !sel;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(negedge lclk);
			link_d.sdi <= w[i];
			sclk_en <= 1'b1;
		end
		@(negedge lclk);
		sclk_en <= 1'b0;
		@(negedge lclk);
		link_d.cs_n <= 1'b1;
		@(negedge lclk);
	endtask : bang
	task automatic pulse_clear;
		clear_req <= 1'b1;
		@(posedge core_clk);
		clear_req <= 1'b0;
	endtask : pulse_clear
	// =====================================================================
	// Stimulus
	// =====================================================================
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// The bench link runs on its own 30 ns clock, out of phase with the core.
	initial
	begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end
	// The run needs about 3000 cycles; this leaves a wide margin.
	initial
	begin
		#100000;
		err_total++;
		give_verdict();
	end
	initial
	begin
		arst_n = 1'b0;
		wr_valid = 1'b0;
		clear_req = 1'b0;
		wr_data = 16'h0000;
		sclk_en = 1'b0;
		link_d.cs_n = 1'b1;
		link_d.sdi = 1'b0;
		link_d.async_clear_n = 1'b1;
		err_total = 0;
		compares = 0;
		refused = 0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		@(negedge core_clk);
		chk(code_a, ZERO_CODE);
		chk(code_b, MID_CODE);
		chk(code_c, ZERO_CODE);
		foreach (rows[i])
		begin
			@(posedge core_clk);
			push(rows[i].w);
			settle();
			chk(code_a, rows[i].w);
			chk(code_b, rows[i].eb);
			chk(code_c, rows[i].ec);
		end
		@(posedge core_clk);
		pulse_clear();
		settle();
		chk(code_a, ZERO_CODE);
		chk(code_b, MID_CODE);
		@(posedge core_clk);
		for (int i = 0; i < 10; i++)
			push(16'hA000 | 16'(i));
		pulse_clear();
		settle();
		chk(16'(refused > 0), 16'h0001);
		chk(code_a, 16'hA009);
		@(posedge core_clk);
		arst_n <= 1'b0;
		@(negedge core_clk);
		chk(code_a, ZERO_CODE);
		chk(code_b, MID_CODE);
		@(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		push(16'hC3A5);
		settle();
		chk(code_a, 16'hC3A5);
		bang(32'h000F1234, 20, 1'b1);
		chk(code_d, 16'h1234);
		bang(32'h0000FFFF, 16, 1'b0);
		chk(code_d, 16'h1234);
		bang(32'h00000000, 0, 1'b1);
		chk(code_d, 16'h1234);
		@(negedge lclk);
		link_d.async_clear_n <= 1'b0;
		bang(32'h0000ABCD, 16, 1'b1);
		chk(code_d, ZERO_CODE);
		@(negedge lclk);
		link_d.async_clear_n <= 1'b1;
		bang(32'h00000000, 0, 1'b1);
		chk(code_d, 16'hABCD);
		@(negedge lclk);
		link_d.async_clear_n <= 1'b0;
		@(negedge lclk);
		link_d.async_clear_n <= 1'b1;
		@(negedge lclk);
		chk(code_d, ZERO_CODE);
		give_verdict();
	end
endmodule : dac_serial_load_logic_tb_top
`default_nettype wire
